/* File: logic/mcs_params.svh */
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

`define MCS_OSC_PER_STATE    2
`define MCS_STATES_PER_CYCLE 6
`define MCS_PH_W             1
`define MCS_STATE_W          3
`define MCS_ADDR_W           16
`define MCS_DATA_W           8
`define MCS_PC_RESET         16'h0000
`define MCS_ACC_RESET        8'h00
`define MCS_ZERO_BYTE        8'h00
`define MCS_ONE_BYTE         8'h01
`define MCS_SFR_BASE         8'h80

`endif

/* File: logic/mcs_pkg.sv */
package mcs_pkg;
  typedef enum logic [2:0] {
    ST_S1 = 3'b000,
    ST_S2 = 3'b001,
    ST_S3 = 3'b010,
    ST_S4 = 3'b011,
    ST_S5 = 3'b100,
    ST_S6 = 3'b101
  } mstate_e;

  typedef enum logic [2:0] {
    OP_SINGLE      = 3'b000,
    OP_EXT_MOVE    = 3'b001,
    OP_ACC_ZERO    = 3'b010,
    OP_ACC_NONZERO = 3'b011,
    OP_DEC_BRANCH  = 3'b100,
    OP_CMP_BRANCH  = 3'b101,
    OP_SFR_WRITE   = 3'b110
  } op_class_e;
endpackage

/* File: logic/branch_unit.sv */
`timescale 1ns/1ps
`include "mcs_params.svh"
module branch_unit
  import mcs_pkg::*;
(
  input  wire logic [2:0]  op_class_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [7:0]  opnd_a_i,
  input  wire logic [7:0]  opnd_b_i,
  input  wire logic [7:0]  rel_i,
  input  wire logic [15:0] pc_next_i,
  output logic             taken_o,
  output logic [7:0]       dec_val_o,
  output logic             carry_valid_o,
  output logic             carry_o,
  output logic [15:0]      target_o
);
  always_comb begin
    dec_val_o     = opnd_a_i - `MCS_ONE_BYTE;
    taken_o       = 1'b0;
    carry_valid_o = 1'b0;
    carry_o       = 1'b0;
    case (op_class_e'(op_class_i))
      OP_ACC_ZERO:    taken_o = (acc_i == `MCS_ZERO_BYTE); // RULE14
      OP_ACC_NONZERO: taken_o = (acc_i != `MCS_ZERO_BYTE); // RULE14
      OP_DEC_BRANCH:  taken_o = (dec_val_o != `MCS_ZERO_BYTE); // RULE9
      OP_CMP_BRANCH: begin
        carry_valid_o = 1'b1;
        carry_o       = (opnd_a_i < opnd_b_i); // RULE15
        taken_o       = (opnd_a_i != opnd_b_i); // RULE15
      end
      default:        taken_o = 1'b0;
    endcase
    // sign-extended offset, reach -128..+127
    target_o = pc_next_i + {{8{rel_i[7]}}, rel_i}; // RULE13
  end
endmodule

/* File: logic/machine_cycle_sequencer.sv */
`timescale 1ns/1ps
`include "mcs_params.svh"
// Contract
// RULE1 - every machine cycle walks states S1 to S6 and then returns to S1.
// RULE2 - each state lasts two oscillator periods, twelve per machine cycle.
// RULE3 - each state has a phase 1 and phase 2 of one period each, ordering fetch and execute.
// RULE4 - two code fetches are issued in each machine cycle even when unneeded.
// RULE5 - an unneeded fetched byte is discarded and the program counter is not advanced for it.
// RULE6 - a single-cycle opcode is latched in S1, the second fetch is in S4, execution ends at end of S6.
// RULE7 - an external data move takes exactly two machine cycles.
// RULE8 - only the second cycle of an external data move suppresses code fetches.
// RULE9 - decrement-branch decrements its operand and branches only on a nonzero result.
// RULE10 - unimplemented special register reads give arbitrary data and writes change nothing.
// RULE11 - software should write only zeros to unimplemented special register locations.
// RULE12 - memory is reached by 16-bit address, 8-bit data, read, write, fetch, latch and reset strobes; the code never drives wr_n_o low.
// RULE13 - a taken branch adds a signed byte to the following instruction address.
// RULE14 - zero-test branches look at the accumulator directly.
// RULE15 - compare-branch is unsigned, carry set when first is smaller, branch when unequal.
// RULE16 - reset restarts at S1 of a fresh cycle with no instruction carried over.
module machine_cycle_sequencer
  import mcs_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [2:0]  op_class_i,
  input  wire logic        needs_byte2_i,
  input  wire logic [7:0]  opnd_b_i,
  input  wire logic        sfr_implemented_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  data_in_i,
  output logic [15:0]      addr_o,
  output logic [7:0]       data_out_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic             code_fetch_strobe_n_o,
  output logic             ale_o,
  output logic             mem_rst_n_o,
  output logic [2:0]       state_o,
  output logic             phase2_o,
  output logic             cycle_end_o,
  output logic [7:0]       instr_reg_o,
  output logic [7:0]       acc_o,
  output logic             carry_o,
  output logic             sfr_write_o
);
  logic [2:0]  state_ff, nxt_state;
  logic        phase_ff, nxt_phase;
  logic        movx2_ff, nxt_movx2;
  logic [15:0] pc_ff, nxt_pc;
  logic [7:0]  ir_ff, nxt_ir;
  logic [7:0]  opnd_ff, nxt_opnd;
  logic [7:0]  acc_ff, nxt_acc;
  logic        carry_ff, nxt_carry;
  logic [15:0] addr_ff, nxt_addr;
  logic [7:0]  dout_ff, nxt_dout;
  logic        rd_n_ff, nxt_rd_n;
  logic        wr_n_ff, nxt_wr_n;
  logic        code_fetch_strobe_n_n_ff, nxt_code_fetch_strobe_n_n;
  logic        ale_ff, nxt_ale;
  logic        rst_n_ff, nxt_rst_n;
  logic        end_ff, nxt_end;
  logic        sfrw_ff, nxt_sfrw;

  logic        br_taken;
  logic [7:0]  br_dec;
  logic        br_cvalid;
  logic        br_carry;
  logic [15:0] br_target;

  branch_unit u_branch (
    .op_class_i    (op_class_i),
    .acc_i         (acc_ff),
    .opnd_a_i      (op_class_i == OP_CMP_BRANCH ? acc_ff : opnd_ff),
    .opnd_b_i      (opnd_b_i),
    .rel_i         (data_in_i),
    .pc_next_i     (pc_ff),
    .taken_o       (br_taken),
    .dec_val_o     (br_dec),
    .carry_valid_o (br_cvalid),
    .carry_o       (br_carry),
    .target_o      (br_target)
  );

  logic fetch_slot;
  logic is_external_data_move;

  always_comb begin
    is_external_data_move    = (op_class_i == OP_EXT_MOVE);
    nxt_state  = state_ff;
    nxt_phase  = ~phase_ff; // RULE3
    nxt_movx2  = movx2_ff;
    nxt_pc     = pc_ff;
    nxt_ir     = ir_ff;
    nxt_opnd   = opnd_ff;
    nxt_acc    = acc_ff;
    nxt_carry  = carry_ff;
    nxt_addr   = addr_ff;
    nxt_dout   = dout_ff;
    nxt_rd_n   = 1'b1;
    nxt_wr_n   = 1'b1;
    nxt_code_fetch_strobe_n_n = 1'b1;
    nxt_ale    = 1'b0;
    nxt_rst_n  = 1'b1;
    nxt_end    = 1'b0;
    nxt_sfrw   = 1'b0;
    // fetch slots in S1 and S4, none in second external_data_move cycle
    fetch_slot = ((state_ff == ST_S1) || (state_ff == ST_S4)) && !movx2_ff; // RULE4 RULE6 RULE8
    if (phase_ff) begin
      // end of phase 2: advance state, two periods per state
      if (state_ff == ST_S6) begin // RULE1 RULE2
        nxt_state = ST_S1;
        nxt_end   = 1'b1; // RULE6
        if (movx2_ff) begin
          nxt_movx2 = 1'b0; // RULE7
        end else if (is_external_data_move) begin
          nxt_movx2 = 1'b1; // RULE7
        end
      end else begin
        nxt_state = state_ff + 3'd1;
      end
    end
    // strobes are registered, so they are raised one period ahead
    if (fetch_slot && !phase_ff) begin
      nxt_code_fetch_strobe_n_n = 1'b0; // RULE12 RULE3
    end
    // capture fetched byte at end of phase 2 of a fetch state
    if (fetch_slot && phase_ff) begin
      if (state_ff == ST_S1) begin
        nxt_ir = data_in_i; // RULE6
        nxt_pc = pc_ff + 16'd1;
      end else if (needs_byte2_i) begin
        nxt_opnd = data_in_i;
        nxt_pc   = pc_ff + 16'd1;
      end
      // else byte discarded, pc held RULE5
    end
    // execute at end of S6
    if (phase_ff && state_ff == ST_S6 && !movx2_ff) begin
      case (op_class_e'(op_class_i))
        OP_ACC_ZERO, OP_ACC_NONZERO: begin
          if (br_taken) nxt_pc = br_target; // RULE13 RULE14
        end
        OP_DEC_BRANCH: begin
          nxt_opnd = br_dec; // RULE9
          if (br_taken) nxt_pc = br_target; // RULE9 RULE13
        end
        OP_CMP_BRANCH: begin
          if (br_cvalid) nxt_carry = br_carry; // RULE15
          if (br_taken) nxt_pc = br_target; // RULE15
        end
        OP_SFR_WRITE: begin
          // unimplemented addresses: no state change
          nxt_sfrw = sfr_implemented_i && (sfr_addr_i >= `MCS_SFR_BASE); // RULE10
        end
        OP_SINGLE: nxt_acc = opnd_ff;
        default: nxt_acc = acc_ff;
      endcase
    end
    // address latch for the coming phase 1 of a fetch state
    if (phase_ff && (nxt_state == ST_S1 || nxt_state == ST_S4)) begin
      if (!nxt_movx2) begin
        nxt_addr = nxt_pc; // RULE12
        nxt_ale  = 1'b1; // RULE3
      end else if (nxt_state == ST_S1 && !movx2_ff) begin
        nxt_addr = {`MCS_ZERO_BYTE, opnd_ff}; // RULE12
        nxt_ale  = 1'b1;
      end
    end
    // external data move read strobe over S3..S5 of second cycle
    if (movx2_ff) begin
      if (nxt_state >= ST_S3 && nxt_state <= ST_S5) begin
        nxt_rd_n = 1'b0; // RULE12 RULE7
      end
      if (state_ff == ST_S5 && phase_ff) begin
        nxt_acc = data_in_i;
      end
    end
    nxt_dout = acc_ff;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin // RULE16
      state_ff  <= ST_S1;
      phase_ff  <= 1'b0;
      movx2_ff  <= 1'b0;
      pc_ff     <= `MCS_PC_RESET;
      ir_ff     <= `MCS_ZERO_BYTE;
      opnd_ff   <= `MCS_ZERO_BYTE;
      acc_ff    <= `MCS_ACC_RESET;
      carry_ff  <= 1'b0;
      addr_ff   <= `MCS_PC_RESET;
      dout_ff   <= `MCS_ZERO_BYTE;
      rd_n_ff   <= 1'b1;
      wr_n_ff   <= 1'b1;
      code_fetch_strobe_n_n_ff <= 1'b1;
      ale_ff    <= 1'b0;
      rst_n_ff  <= 1'b0;
      end_ff    <= 1'b0;
      sfrw_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      phase_ff  <= nxt_phase;
      movx2_ff  <= nxt_movx2;
      pc_ff     <= nxt_pc;
      ir_ff     <= nxt_ir;
      opnd_ff   <= nxt_opnd;
      acc_ff    <= nxt_acc;
      carry_ff  <= nxt_carry;
      addr_ff   <= nxt_addr;
      dout_ff   <= nxt_dout;
      rd_n_ff   <= nxt_rd_n;
      wr_n_ff   <= nxt_wr_n;
      code_fetch_strobe_n_n_ff <= nxt_code_fetch_strobe_n_n;
      ale_ff    <= nxt_ale;
      rst_n_ff  <= nxt_rst_n;
      end_ff    <= nxt_end;
      sfrw_ff   <= nxt_sfrw;
    end
  end

  assign addr_o                = addr_ff;
  assign data_out_o            = dout_ff;
  assign rd_n_o                = rd_n_ff;
  assign wr_n_o                = wr_n_ff;
  assign code_fetch_strobe_n_o = code_fetch_strobe_n_n_ff;
  assign ale_o                 = ale_ff;
  assign mem_rst_n_o           = rst_n_ff;
  assign state_o               = state_ff;
  assign phase2_o              = phase_ff;
  assign cycle_end_o           = end_ff;
  assign instr_reg_o           = ir_ff;
  assign acc_o                 = acc_ff;
  assign carry_o               = carry_ff;
  assign sfr_write_o           = sfrw_ff;
endmodule

/* File: sim/mcs_checker_props.sv */
`timescale 1ns/1ps
module mcs_checker (
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       sfr_implemented_i,
  input wire logic       rd_n_o,
  input wire logic       code_fetch_strobe_n_o,
  input wire logic       ale_o,
  input wire logic       mem_rst_n_o,
  input wire logic [2:0] state_o,
  input wire logic       phase2_o,
  input wire logic       cycle_end_o,
  input wire logic       sfr_write_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_wrap; phase2_o |=> !phase2_o && state_o == ($past(state_o) == 3'h5 ? 3'h0 : $past(state_o) + 3'h1);
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad state step");
  property p_half; !phase2_o |=> phase2_o && $stable(state_o); endproperty
  a_half: assert property (p_half) else $error("bad phase step");
  property p_fetch; !code_fetch_strobe_n_o |-> phase2_o && (state_o == 3'h0 || state_o == 3'h3); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch off slot");
  property p_ale; ale_o |-> !phase2_o && (state_o == 3'h0 || state_o == 3'h3); endproperty
  a_ale: assert property (p_ale) else $error("latch off slot");
  property p_end; cycle_end_o |-> state_o == 3'h0 && !phase2_o && $past(state_o) == 3'h5; endproperty
  a_end: assert property (p_end) else $error("cycle end misplaced");
  property p_rd; !rd_n_o |-> state_o inside {3'h2, 3'h3, 3'h4}; endproperty
  a_rd: assert property (p_rd) else $error("read off slot");
  property p_nofetch; $fell(rd_n_o) |-> code_fetch_strobe_n_o [*6]; endproperty
  a_nofetch: assert property (p_nofetch) else $error("fetch in move cycle");
  property p_sfr; sfr_write_o |-> sfr_implemented_i ##1 !sfr_write_o; endproperty
  a_sfr: assert property (p_sfr) else $error("bad register write");
  property p_mrst; !mem_rst_n_o |-> $past(sys_rst_i); endproperty
  a_mrst: assert property (p_mrst) else $error("memory reset stuck");
  c_end: cover property (cycle_end_o);
  c_move: cover property ($fell(rd_n_o));
  c_sfr: cover property (sfr_write_o);
endmodule
bind machine_cycle_sequencer mcs_checker mcs_checker_inst (.sys_clk_i, .sys_rst_i, .sfr_implemented_i, .rd_n_o,
  .code_fetch_strobe_n_o, .ale_o, .mem_rst_n_o, .state_o, .phase2_o, .cycle_end_o, .sfr_write_o);

/* File: sim/mem_model.sv */
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        fetch_n_i,
  input  wire logic        rd_n_i,
  output logic [7:0]       data_o
);
  logic [7:0] junk_ff = 8'h3c;
  // released bus shows a changing pattern
  always @(posedge clk_i) junk_ff <= ~junk_ff;
  assign data_o = (!fetch_n_i || !rd_n_i) ? addr_i[7:0] ^ 8'h5a : junk_ff;
endmodule

/* File: sim/machine_cycle_sequencer_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module machine_cycle_sequencer_tb
  import mcs_pkg::*;
;
  logic        sys_clk_i, sys_rst_i, needs_byte2_i, sfr_implemented_i, rd_n_o, wr_n_o, code_fetch_strobe_n_o;
  logic        ale_o, mem_rst_n_o, phase2_o, cycle_end_o, carry_o, sfr_write_o;
  logic [2:0]  op_class_i, state_o;
  logic [7:0]  opnd_b_i, sfr_addr_i, data_in_i, data_out_o, instr_reg_o, acc_o;
  logic [15:0] addr_o, a0;
  int          error_cnt, comparisons, clk_cnt, n_fetch, n_rd, n_end, n_sfr;
  op_class_e   ops [6] = '{OP_SINGLE, OP_ACC_ZERO, OP_ACC_NONZERO, OP_DEC_BRANCH, OP_CMP_BRANCH, OP_SFR_WRITE};
  machine_cycle_sequencer machine_cycle_sequencer_inst (.sys_clk_i, .sys_rst_i, .op_class_i, .needs_byte2_i,
    .opnd_b_i, .sfr_implemented_i, .sfr_addr_i, .data_in_i, .addr_o, .data_out_o, .rd_n_o, .wr_n_o,
    .code_fetch_strobe_n_o, .ale_o, .mem_rst_n_o, .state_o, .phase2_o, .cycle_end_o, .instr_reg_o, .acc_o,
    .carry_o, .sfr_write_o);
  mem_model mem_model_inst (.clk_i(sys_clk_i), .addr_i(addr_o), .fetch_n_i(code_fetch_strobe_n_o),
    .rd_n_i(rd_n_o), .data_o(data_in_i));
  task automatic step();
    @(posedge sys_clk_i);
    #2;
  endtask
  task automatic sync();
    int k;
    k = 0;
    do begin step(); k++; end while (cycle_end_o !== 1'b1 && k < 40);
    a0 = addr_o;
    `CHK(k < 40, 1'b1)
  endtask
  task automatic run(input int n);
    n_fetch = 0; n_rd = 0; n_end = 0; n_sfr = 0;
    repeat (n) begin
      step();
      n_fetch += (code_fetch_strobe_n_o === 1'b0);
      n_rd += (rd_n_o === 1'b0);
      n_end += (cycle_end_o === 1'b1);
      n_sfr += (sfr_write_o === 1'b1);
    end
  endtask
  task automatic t_classes();
    foreach (ops[i]) begin
      op_class_i = ops[i];
      sync();
      run(12);
      `CHK(n_fetch, 2)
      `CHK(n_end, 1)
    end
    $display("classes done");
  endtask
  task automatic t_carry(input logic [7:0] b, input logic exp);
    op_class_i = OP_CMP_BRANCH;
    opnd_b_i = b;
    sync();
    sync();
    `CHK(carry_o, exp)
    $display("carry done");
  endtask
  task automatic t_pc(input logic nb, input logic [15:0] d);
    logic [15:0] a1;
    op_class_i = OP_SINGLE;
    needs_byte2_i = nb;
    sync();
    sync();
    a1 = a0;
    sync();
    `CHK(a0 - a1, d)
    $display("pc done");
  endtask
  task automatic t_move();
    op_class_i = OP_EXT_MOVE;
    sync();
    op_class_i = OP_SINGLE;
    run(24);
    `CHK(n_fetch, 2)
    `CHK(n_rd, 6)
    $display("move done");
  endtask
  task automatic t_sfr(input logic impl, input int exp);
    logic [7:0] acc0;
    sync();
    acc0 = acc_o;
    op_class_i = OP_SFR_WRITE;
    sfr_addr_i = 8'h85;
    sfr_implemented_i = impl;
    run(12);
    `CHK(n_sfr, exp)
    `CHK(acc_o, acc0)
    op_class_i = OP_SINGLE;
    $display("register write done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    clk_cnt++;
    if (clk_cnt == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    sys_rst_i = 1'b1; op_class_i = OP_SINGLE; needs_byte2_i = 1'b0; opnd_b_i = 8'h00;
    sfr_implemented_i = 1'b0; sfr_addr_i = 8'h80;
    repeat (8) @(posedge sys_clk_i);
    #2 sys_rst_i = 1'b0;
    t_carry(8'h05, 1'b1);
    t_carry(8'h00, 1'b0);
    t_classes();
    t_pc(1'b0, 16'h0001);
    t_pc(1'b1, 16'h0002);
    t_move();
    // register write cycle: acc keeps its value from before
    t_sfr(1'b0, 0);
    t_sfr(1'b1, 1);
    wrap_up();
  end
endmodule
